// File: shared/cbcfg_pkg.sv
// Charger configuration bank: addresses, fields, reset values, carriers.
// Assumes one device clock; the serial port engine lives outside.
package cbcfg_pkg;

	// Register addresses on the serial control port
	localparam logic [7:0] CBCFG_ADDR_MASK = 8'h0a;
	localparam logic [7:0] CBCFG_ADDR_VBAT = 8'h12;
	localparam logic [7:0] CBCFG_ADDR_FAST = 8'h13;
	localparam logic [7:0] CBCFG_ADDR_PCHG = 8'h14;
	localparam logic [7:0] CBCFG_ADDR_TERM = 8'h15;
	localparam logic [7:0] CBCFG_ADDR_FLAGS = 8'h06;

	// Reset values
	localparam logic [7:0] CBCFG_RST_MASK = 8'h00;
	localparam logic [7:0] CBCFG_RST_VBAT = 8'h3c;
	localparam logic [7:0] CBCFG_RST_FAST = 8'h36;
	localparam logic [7:0] CBCFG_RST_PCHG = 8'h07;
	localparam logic [7:0] CBCFG_RST_TERM = 8'h14;

	// Event and mask bit positions (shared by flags and mask)
	localparam int CBCFG_BIT_WATCHDOG = 6;
	localparam int CBCFG_BIT_TIMEOUT = 5;
	localparam int CBCFG_BIT_OVERCUR = 4;
	localparam int CBCFG_BIT_WAKE1 = 2;
	localparam int CBCFG_BIT_WAKE2 = 1;
	localparam int CBCFG_BIT_RSTWARN = 0;
	localparam logic [7:0] CBCFG_EVENT_BITS = 8'h77;

	// Field positions
	localparam int CBCFG_RANGE_BIT = 7;
	localparam int CBCFG_TERM_LSB = 1;
	localparam int CBCFG_TERM_OFF_BIT = 0;

	// Scaling of codes into physical units
	localparam logic [12:0] CBCFG_VREG_BASE_MV = 13'h0e10;
	localparam logic [12:0] CBCFG_VREG_STEP_MV = 13'h000a;
	localparam logic [6:0] CBCFG_VREG_MAX_CODE = 7'h64;
	localparam logic [11:0] CBCFG_STEP_FINE_UA = 12'h4e2;
	localparam logic [11:0] CBCFG_STEP_COARSE_UA = 12'h9c4;
	localparam logic [6:0] CBCFG_PCT_SCALE = 7'h64;

	// One access from the serial port engine
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} cbcfg_req_t;

	// Decoded settings handed to the charger core
	typedef struct packed {
		logic [12:0] vreg_mv;
		logic [19:0] fast_ua;
		logic [16:0] pre_ua;
		logic [4:0] term_pct;
		logic term_on;
	} cbcfg_set_t;

endpackage

// File: verilog/cbcfg_flag_cell.sv
// One sticky event flag, cleared by a read of the flag register.
// Assumes the event and clear are synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module cbcfg_flag_cell (
	input wire logic sys_clk, // Device clock
	input wire logic rst, // Async reset, active high
	input wire logic event_hit, // Event seen this cycle
	input wire logic clear, // Flag register read
	output logic flag // Latched event
);
	logic next_flag;

	// Set wins over clear so a coincident event is not lost
	assign next_flag = event_hit | (flag & ~clear);

	// Flag storage
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flag <= 1'b0;
		end else begin
			flag <= next_flag;
		end
	end
endmodule
`default_nettype wire

// File: verilog/cbcfg_current_scale.sv
// Current code to microamps, with a fine or coarse step.
// Assumes code and range come from registered configuration.
`timescale 1ns/1ps
`default_nettype none
module cbcfg_current_scale #(
	parameter int CODE_W = 8, // Code width
	parameter int OUT_W = CODE_W + 12 // Result width in microamps
) (
	input wire logic [CODE_W-1:0] code, // Current code
	input wire logic coarse, // High selects the larger step
	output logic [OUT_W-1:0] level_ua // Current in microamps
);
	import cbcfg_pkg::*;
	logic [OUT_W-1:0] step_ua;

	// Step chosen by the range bit, then one multiply
	assign step_ua = coarse ? OUT_W'(CBCFG_STEP_COARSE_UA)
		: OUT_W'(CBCFG_STEP_FINE_UA);
	assign level_ua = OUT_W'(OUT_W'(code) * step_ua);
endmodule
`default_nettype wire

// File: verilog/cbcfg_regs.sv
// Charger configuration and interrupt mask register bank.
// Assumes the serial port engine presents decoded byte accesses,
// one per cycle at most, synchronous to sys_clk.
//
// Behaviour
// - Mask bit 6 blocks watchdog interrupt
// - Mask bit 5 blocks charge timeout interrupt
// - Mask bit 4 blocks regulator overcurrent interrupt
// - Mask bits 2, 1 block wake timers
// - Mask bit 0 blocks reset warning
// - Mask at 0x0a, reset zero, reserved writable
// - Voltage is 3.6 V plus code times 10mV
// - Codes above 4.6 V stored as 4.6V
// - Range zero: fast current 1.25 mA steps
// - Range one: fast current 2.5 mA steps
// - Fast current register resets to 0x36
// - Bit 7 picks pre-charge step size
// - Fine range: pre-charge 1.25 mA per code
// - Coarse range: pre-charge 2.5 mA per code
// - Pre-charge at 0x14, reset 0x07
// - Termination at 0x15, reset 0x14
// - Terminate at code percent of fast current
// - Termination-off bit stops charge termination
// - Event flags latch, clear on read
`timescale 1ns/1ps
`default_nettype none
module cbcfg_regs (
	input wire logic sys_clk, // Device clock, 20 MHz
	input wire logic rst, // Async reset, active high
	input wire cbcfg_pkg::cbcfg_req_t req, // Byte access from port
	output logic [7:0] rdata, // Read data, registered
	output logic rvalid, // Read data valid, one cycle
	input wire logic [7:0] evt, // Event pulses at flag positions
	input wire logic charging, // Charger in fast charge
	input wire logic [19:0] meas_ua, // Measured charge current
	output cbcfg_pkg::cbcfg_set_t settings, // Decoded settings
	output logic charge_done, // Termination reached
	output logic host_irq_n // Interrupt to host, active low
);
	import cbcfg_pkg::*;

	// Decoded settings at reset, derived from register resets
	localparam logic [12:0] VREG_RST_MV = CBCFG_VREG_BASE_MV
		+ 13'(CBCFG_RST_VBAT[6:0]) * CBCFG_VREG_STEP_MV;
	localparam logic [19:0] FAST_RST_UA = 20'(CBCFG_RST_FAST)
		* 20'(CBCFG_STEP_FINE_UA);
	localparam logic [16:0] PRE_RST_UA = 17'(CBCFG_RST_PCHG[4:0])
		* 17'(CBCFG_STEP_FINE_UA);

	logic [7:0] irq_mask;
	logic [7:0] vbat;
	logic [7:0] fast_charge_current;
	logic [7:0] pchg;
	logic [7:0] term;
	logic [7:0] flags;

	// Address decode
	wire hit_mask = req.addr == CBCFG_ADDR_MASK;
	wire hit_vbat = req.addr == CBCFG_ADDR_VBAT;
	wire hit_fast = req.addr == CBCFG_ADDR_FAST;
	wire hit_pchg = req.addr == CBCFG_ADDR_PCHG;
	wire hit_term = req.addr == CBCFG_ADDR_TERM;
	wire hit_flags = req.addr == CBCFG_ADDR_FLAGS;
	wire flag_clear = req.rd & hit_flags;

	// Voltage code limited before it is stored
	wire [6:0] vcode_in = req.wdata[6:0];
	wire [6:0] vcode_lim = (vcode_in > CBCFG_VREG_MAX_CODE)
		? CBCFG_VREG_MAX_CODE : vcode_in;
	wire [7:0] next_vbat = {req.wdata[7], vcode_lim};

	// Mask register; reserved bits 7 and 3 stored as written
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			irq_mask <= CBCFG_RST_MASK;
		end else if (req.wr && hit_mask) begin
			irq_mask <= req.wdata;
		end
	end

	// Charger configuration registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vbat <= CBCFG_RST_VBAT;
			fast_charge_current <= CBCFG_RST_FAST;
			pchg <= CBCFG_RST_PCHG;
			term <= CBCFG_RST_TERM;
		end else if (req.wr) begin
			if (hit_vbat) vbat <= next_vbat;
			if (hit_fast) fast_charge_current <= req.wdata;
			if (hit_pchg) pchg <= req.wdata;
			if (hit_term) term <= req.wdata;
		end
	end

	// One sticky flag per implemented event; others read zero
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_flag
			if (CBCFG_EVENT_BITS[gi]) begin : g_on
				cbcfg_flag_cell u_flag (
					.sys_clk(sys_clk),
					.rst(rst),
					.event_hit(evt[gi]),
					.clear(flag_clear),
					.flag(flags[gi])
				);
			end else begin : g_off
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	// Masked events still latch; the mask only gates the pin
	wire [7:0] irq_live = flags & ~irq_mask & CBCFG_EVENT_BITS;
	wire next_irq_n = ~|irq_live;

	// Readback mux; unmapped addresses read zero
	wire [7:0] read_mux = hit_mask ? irq_mask
		: hit_vbat ? vbat
		: hit_fast ? fast_charge_current
		: hit_pchg ? pchg
		: hit_term ? term
		: hit_flags ? flags
		: 8'h00;

	// Read data captured before the flags clear on the same edge
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req.rd;
			if (req.rd) rdata <= read_mux;
		end
	end

	// Current scaling shares one range bit for both currents
	wire coarse = pchg[CBCFG_RANGE_BIT];
	logic [19:0] fast_ua;
	logic [16:0] pre_ua;

	cbcfg_current_scale #(
		.CODE_W(8),
		.OUT_W(20)
	) u_fast (
		.code(fast_charge_current),
		.coarse(coarse),
		.level_ua(fast_ua)
	);

	cbcfg_current_scale #(
		.CODE_W(5),
		.OUT_W(17)
	) u_pre (
		.code(pchg[4:0]),
		.coarse(coarse),
		.level_ua(pre_ua)
	);

	// Regulation voltage in millivolts
	wire [12:0] vreg_mv = CBCFG_VREG_BASE_MV
		+ 13'(13'(vbat[6:0]) * CBCFG_VREG_STEP_MV);

	// Termination fields
	wire [4:0] term_code = term[CBCFG_TERM_LSB +: 5];
	wire term_on = ~term[CBCFG_TERM_OFF_BIT];

	// Percentage compare without a divider: meas*100 <= fast*code
	wire [26:0] meas_scaled = 27'(meas_ua) * 27'(CBCFG_PCT_SCALE);
	wire [26:0] term_limit = 27'(fast_ua) * 27'(term_code);
	// Code zero is not a legal level, so it never terminates
	wire next_done = charging & term_on & (term_code != 5'h00)
		& (meas_scaled <= term_limit);

	cbcfg_set_t next_settings;
	assign next_settings = '{
		vreg_mv: vreg_mv,
		fast_ua: fast_ua,
		pre_ua: pre_ua,
		term_pct: term_code,
		term_on: term_on
	};

	// Outputs registered to keep the multipliers off the pins
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			settings <= '{
				vreg_mv: VREG_RST_MV,
				fast_ua: FAST_RST_UA,
				pre_ua: PRE_RST_UA,
				term_pct: CBCFG_RST_TERM[5:1],
				term_on: 1'b1
			};
			charge_done <= 1'b0;
			host_irq_n <= 1'b1;
		end else begin
			settings <= next_settings;
			charge_done <= next_done;
			host_irq_n <= next_irq_n;
		end
	end

	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_wd_latched;
		evt[CBCFG_BIT_WATCHDOG] ##1 flags[CBCFG_BIT_WATCHDOG];
	endsequence

	sequence s_flag_read_quiet;
		flag_clear && !evt[CBCFG_BIT_WATCHDOG];
	endsequence

	a_watchdog_irq_pass: assert property (
		flags[CBCFG_BIT_WATCHDOG] && !irq_mask[CBCFG_BIT_WATCHDOG]
		|=> !host_irq_n)
		else $error("unmasked watchdog flag gave no interrupt");

	a_timeout_irq_block: assert property (
		(flags == 8'h20) && irq_mask[CBCFG_BIT_TIMEOUT] |=> host_irq_n)
		else $error("masked timeout flag raised the interrupt");

	a_overcur_irq_pass: assert property (
		flags[CBCFG_BIT_OVERCUR] && !irq_mask[CBCFG_BIT_OVERCUR]
		|=> !host_irq_n)
		else $error("unmasked overcurrent flag gave no interrupt");

	a_wake_irq_pass: assert property (
		(flags[CBCFG_BIT_WAKE1] && !irq_mask[CBCFG_BIT_WAKE1])
		|| (flags[CBCFG_BIT_WAKE2] && !irq_mask[CBCFG_BIT_WAKE2])
		|=> !host_irq_n)
		else $error("unmasked wake flag gave no interrupt");

	a_irq_only_unmasked: assert property (
		((flags & ~irq_mask) == 8'h00) |=> host_irq_n)
		else $error("interrupt raised with every flag masked");

	a_vreg_clamp_write: assert property (
		req.wr && hit_vbat && (req.wdata[6:0] > 7'h64)
		|=> vbat[6:0] == 7'h64 ##1 settings.vreg_mv == 13'h11f8)
		else $error("over-limit voltage code not held at limit");

	a_vreg_scale: assert property (
		req.wr && hit_vbat && (req.wdata[6:0] <= 7'h64)
		|-> ##2 settings.vreg_mv
		== 13'h0e10 + 13'(13'($past(req.wdata[6:0], 2)) * 13'h000a))
		else $error("regulation voltage not base plus code steps");

	a_fast_scale: assert property (
		req.wr && hit_fast |-> ##2 settings.fast_ua
		== 20'($past(req.wdata, 2))
		* ($past(coarse) ? 20'(CBCFG_STEP_COARSE_UA)
		: 20'(CBCFG_STEP_FINE_UA)))
		else $error("fast current not code times step");

	a_flag_latch: assert property (
		evt[CBCFG_BIT_OVERCUR] |=> flags[CBCFG_BIT_OVERCUR])
		else $error("event did not latch its flag");

	a_flag_read_clear: assert property (
		s_flag_read_quiet |=> !flags[CBCFG_BIT_WATCHDOG])
		else $error("flag not cleared by a read");

	a_wd_flag_latch: assert property (
		evt[CBCFG_BIT_WATCHDOG] |-> s_wd_latched)
		else $error("watchdog event did not latch its flag");

	a_timeout_irq_pass: assert property (
		flags[CBCFG_BIT_TIMEOUT] && !irq_mask[CBCFG_BIT_TIMEOUT]
		|=> !host_irq_n)
		else $error("unmasked timeout flag gave no interrupt");

	a_rstwarn_irq_pass: assert property (
		flags[CBCFG_BIT_RSTWARN] && !irq_mask[CBCFG_BIT_RSTWARN]
		|=> !host_irq_n)
		else $error("unmasked reset warning flag gave no interrupt");

	a_mask_readback: assert property (
		req.rd && hit_mask |=> rvalid && (rdata == $past(irq_mask)))
		else $error("mask register read back wrong");

	a_pre_scale: assert property (
		req.wr && hit_pchg |-> ##2 settings.pre_ua
		== 17'($past(req.wdata[4:0], 2))
		* ($past(req.wdata[CBCFG_RANGE_BIT], 2)
		? 17'(CBCFG_STEP_COARSE_UA) : 17'(CBCFG_STEP_FINE_UA)))
		else $error("pre-charge current not code times step");

	a_pchg_store: assert property (
		req.wr && hit_pchg |=> pchg == $past(req.wdata))
		else $error("pre-charge register did not keep written bits");

	a_term_store: assert property (
		req.wr && hit_term |=> term == $past(req.wdata))
		else $error("termination register did not keep written bits");

	a_term_off: assert property (
		!term_on |=> !charge_done)
		else $error("termination fired while disabled");

	a_term_zero_code: assert property (
		term_code == 5'h00 |=> !charge_done)
		else $error("termination fired on code zero");
endmodule
`default_nettype wire

// File: verification/cbcfg_host.sv
// Host model: issues single byte accesses on the register port.
// Assumes one caller at a time; answer due one cycle after a strobe.
`timescale 1ns/1ps
`default_nettype none
module cbcfg_host (
	input wire logic sys_clk, // Device clock
	input wire logic [7:0] rdata, // Read data
	input wire logic rvalid, // Read data valid
	output cbcfg_pkg::cbcfg_req_t req, // Access to the bank
	output logic ack_ok // Valid seen only for reads
);
	import cbcfg_pkg::*;
	initial begin
		req = '0;
		ack_ok = 1'b0;
	end
	// Idle bus shows inverted values so stale data cannot match
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge sys_clk);
		req <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
		@(posedge sys_clk);
		req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
		ack_ok = (rvalid === ~wr);
		q = rdata;
	endtask
endmodule
`default_nettype wire

// File: verification/cbcfg_regs_test.sv
// Self-checking bench for the configuration bank.
// Assumes the host model drives the port; events driven here.
`timescale 1ns/1ps
`default_nettype none
module cbcfg_regs_test;
	import cbcfg_pkg::*;
	logic sys_clk = 1'b0;
	logic rst;
	cbcfg_req_t req;
	logic [7:0] rdata, evt;
	logic rvalid, charging, charge_done, host_irq_n, ack_ok;
	logic [19:0] meas_ua;
	cbcfg_set_t settings;
	int mismatches = 0;
	int cmp_count = 0;
	int bits[6] = '{6, 5, 4, 2, 1, 0};

	cbcfg_regs i_cbcfg_regs (.sys_clk(sys_clk), .rst(rst), .req(req),
		.rdata(rdata), .rvalid(rvalid), .evt(evt), .charging(charging),
		.meas_ua(meas_ua), .settings(settings),
		.charge_done(charge_done), .host_irq_n(host_irq_n));
	cbcfg_host i_cbcfg_host (.sys_clk(sys_clk), .rdata(rdata),
		.rvalid(rvalid), .req(req), .ack_ok(ack_ok));

	// 20 MHz clock
	always #25 sys_clk = ~sys_clk;

	task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] q;
		i_cbcfg_host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] q;
		i_cbcfg_host.access(1'b0, a, 8'h00, q);
		chk({19'h0, ack_ok}, 20'h1);
		chk({12'h0, q}, {12'h0, exp});
	endtask
	// Registered settings land two edges after the write
	task automatic settle();
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic pulse(input int b);
		@(posedge sys_clk);
		evt <= 8'h01 << b;
		@(posedge sys_clk);
		evt <= 8'h00;
		settle();
	endtask
	task automatic irq(input logic exp);
		chk({19'h0, host_irq_n}, {19'h0, exp});
	endtask
	task automatic term(input logic [19:0] m, input logic exp);
		@(posedge sys_clk);
		meas_ua <= m;
		settle();
		chk({19'h0, charge_done}, {19'h0, exp});
	endtask
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		evt = 8'h00;
		charging = 1'b0;
		meas_ua = 20'h0;
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		chk(20'(settings.vreg_mv), 20'd4200);
		chk(settings.fast_ua, 20'd67500);
		chk(20'(settings.pre_ua), 20'd8750);
		chk({14'h0, settings.term_pct, settings.term_on}, 20'h15);
		rd(8'h0a, 8'h00);
		rd(8'h12, 8'h3c);
		rd(8'h13, 8'h36);
		rd(8'h14, 8'h07);
		rd(8'h15, 8'h14);
		irq(1'b1);
		$display("test reset done");
		// Reserved bits writable, unmapped place reads zero
		wr(8'h0a, 8'hff);
		rd(8'h0a, 8'hff);
		wr(8'h14, 8'h60);
		rd(8'h14, 8'h60);
		wr(8'h30, 8'haa);
		rd(8'h30, 8'h00);
		wr(8'h12, 8'h64);
		rd(8'h12, 8'h64);
		settle();
		chk(20'(settings.vreg_mv), 20'd4600);
		wr(8'h12, 8'h65);
		rd(8'h12, 8'h64);
		wr(8'h12, 8'hff);
		rd(8'h12, 8'he4);
		wr(8'h12, 8'h00);
		settle();
		chk(20'(settings.vreg_mv), 20'd3600);
		$display("test access done");
		wr(8'h13, 8'h50);
		wr(8'h14, 8'h1f);
		settle();
		chk(settings.fast_ua, 20'd100000);
		chk(20'(settings.pre_ua), 20'd38750);
		wr(8'h14, 8'h9f);
		settle();
		chk(settings.fast_ua, 20'd200000);
		chk(20'(settings.pre_ua), 20'd77500);
		$display("test current done");
		// Fast current 100 mA, ten percent threshold
		wr(8'h14, 8'h00);
		@(posedge sys_clk);
		charging <= 1'b1;
		term(20'd10000, 1'b1);
		term(20'd10001, 1'b0);
		wr(8'h15, 8'h3e);
		term(20'd31000, 1'b1);
		wr(8'h15, 8'h3f);
		term(20'd100, 1'b0);
		wr(8'h15, 8'h00);
		term(20'd0, 1'b0);
		$display("test termination done");
		// Each event masked alone, then unmasked alone
		foreach (bits[i]) begin
			wr(8'h0a, 8'h01 << bits[i]);
			pulse(bits[i]);
			irq(1'b1);
			rd(8'h06, 8'h01 << bits[i]);
			rd(8'h06, 8'h00);
			wr(8'h0a, ~(8'h01 << bits[i]));
			pulse(bits[i]);
			irq(1'b0);
			rd(8'h06, 8'h01 << bits[i]);
			settle();
			irq(1'b1);
		end
		wr(8'h0a, 8'h00);
		pulse(7);
		pulse(3);
		irq(1'b1);
		rd(8'h06, 8'h00);
		$display("test events done");
		wrap_up();
	end
endmodule
`default_nettype wire
